// [verilog/mpsa_slave.sv]
// two-wire slave with stuck-bus timer, pointer and alert response
`timescale 1ns/1ps
`default_nettype none
module mpsa_slave #(
   parameter int STUCK_CYCLES = mpsa_pkg::STUCK_CYC,
   parameter bit INVERT_OUT = 1'b0
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // bus pins
   input wire logic i_scl,
   input wire logic i_serial_data_in,
   output logic o_serial_data_out,
   // address straps, two bits per pin (low, high, floating)
   input wire logic [1:0] i_addr_select_pin_0,
   input wire logic [1:0] i_addr_select_pin_1,
   // fault and enable words from register file
   input wire logic [31:0] i_fault_flags,
   input wire logic [31:0] i_alert_enable,
   input wire logic i_alert_on_address,
   // alert pin, active low
   output logic o_alert_out_pin_n,
   // register file port
   output logic [7:0] o_reg_ptr,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata,
   input wire logic [7:0] i_reg_rdata
);
   import mpsa_pkg::*;

   // -----------------------------------------------
   // input synchronisers and edge detection
   // -----------------------------------------------
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   // three flops on each pin: two synchronise, one holds the last value for edges
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], i_scl};
         sda_sync_reg <= {sda_sync_reg[0], i_serial_data_in};
         scl_d_reg <= scl_sync_reg[1];
         sda_d_reg <= sda_sync_reg[1];
      end
   end
   wire scl = scl_sync_reg[1];
   wire sda = sda_sync_reg[1];
   wire scl_rise = scl & ~scl_d_reg;
   wire scl_fall = ~scl & scl_d_reg;
   wire start_det = scl & scl_d_reg & ~sda & sda_d_reg;
   wire stop_det = scl & scl_d_reg & sda & ~sda_d_reg;

   // -----------------------------------------------
   // address decode from straps
   // -----------------------------------------------
   // map a strap pair to low address bits 7..15 as the address table orders them
   function automatic logic [3:0] strap_low(input logic [1:0] p1, input logic [1:0] p0);
      logic [3:0] r;
      r = 4'h7;
      case ({p1, p0})
         {STRAP_H, STRAP_L}: r = 4'h7;
         {STRAP_NC, STRAP_H}: r = 4'h8;
         {STRAP_H, STRAP_H}: r = 4'h9;
         {STRAP_NC, STRAP_NC}: r = 4'hA;
         {STRAP_NC, STRAP_L}: r = 4'hB;
         {STRAP_L, STRAP_H}: r = 4'hC;
         {STRAP_L, STRAP_NC}: r = 4'hD;
         {STRAP_H, STRAP_NC}: r = 4'hE;
         {STRAP_L, STRAP_L}: r = 4'hF;
         default: r = 4'h7;
      endcase
      return r;
   endfunction
   logic [3:0] strap0_reg;
   logic [3:0] strap1_reg;
   // two 2-bit stages per strap pin, reset takes constants only
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         strap0_reg <= 4'h0;
         strap1_reg <= 4'h0;
      end else begin
         strap0_reg <= {strap0_reg[1:0], i_addr_select_pin_0};
         strap1_reg <= {strap1_reg[1:0], i_addr_select_pin_1};
      end
   end
   // fixed top bits plus strap bits
   wire [6:0] own_addr = {ADDR_TOP, strap_low(strap1_reg[3:2], strap0_reg[3:2])};

   // -----------------------------------------------
   // stuck-bus timer
   // -----------------------------------------------
   logic [23:0] stuck_cnt_reg;
   logic stuck_reg;
   wire any_low = ~scl | ~sda;
   wire stuck_hit = (stuck_cnt_reg == 24'(STUCK_CYCLES - 1));
   // count while a line is low, clear when both high
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         stuck_cnt_reg <= 24'h0;
         stuck_reg <= 1'b0;
      end else begin
         if (!any_low) begin
            stuck_cnt_reg <= 24'h0;
         end else if (!stuck_hit) begin
            stuck_cnt_reg <= stuck_cnt_reg + 24'h1;
         end
         stuck_reg <= any_low & stuck_hit;
      end
   end

   // -----------------------------------------------
   // alert latch
   // -----------------------------------------------
   logic alert_active;
   logic release_reg;
   mpsa_alert u_alert (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_fault_flags(i_fault_flags),
      .i_alert_enable(i_alert_enable),
      .i_release(release_reg),
      .o_alert_active(alert_active)
   );

   // -----------------------------------------------
   // transaction state machine
   // -----------------------------------------------
   mpsa_state_t state_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic ack_reg;
   logic drive_reg;
   logic rd_mode_reg;
   logic reload_reg;
   logic wr_reg;
   logic [7:0] wdata_reg;

   wire [7:0] rx_byte = {shift_reg[6:0], sda};
   wire [6:0] rx_addr = rx_byte[7:1];
   wire rx_rw = rx_byte[0];
   // msb of the shift register goes out first
   wire tx_bit = shift_reg[7];
   wire hit_own = (rx_addr == own_addr);
   wire hit_mass = (rx_addr == MASS_WR_ADDR) & ~rx_rw;
   // alert address only while alert pending
   wire hit_ara = (rx_addr == ALERT_RESP_ADDR) & rx_rw & alert_active;
   wire [7:0] ptr_inc = (ptr_reg == PTR_LAST) ? PTR_RESET : ptr_reg + 8'h1;
   wire byte_done = scl_rise & (bit_reg == BIT_LAST);
   wire ack_clk = scl_rise & (bit_reg == BIT_ACK);

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= MPSA_IDLE;
         bit_reg <= 4'h0;
         shift_reg <= 8'h0;
         ptr_reg <= PTR_RESET;
         ack_reg <= 1'b0;
         drive_reg <= 1'b0;
         rd_mode_reg <= 1'b0;
         reload_reg <= 1'b0;
         wr_reg <= 1'b0;
         wdata_reg <= 8'h0;
         release_reg <= 1'b0;
      end else begin
         wr_reg <= 1'b0;
         release_reg <= 1'b0;
         reload_reg <= 1'b0;
         if (stuck_reg) begin
            // timeout drops drive and ack, pointer kept; idle until START
            state_reg <= MPSA_IDLE;
            drive_reg <= 1'b0;
            ack_reg <= 1'b0;
         end else if (start_det) begin
            state_reg <= MPSA_ADDR;
            bit_reg <= 4'h0;
            rd_mode_reg <= 1'b0;
            drive_reg <= 1'b0;
            ack_reg <= 1'b0;
         end else if (stop_det) begin
            // stop ends transfer, pointer to zero
            state_reg <= MPSA_IDLE;
            ptr_reg <= PTR_RESET;
            drive_reg <= 1'b0;
         end else if (state_reg != MPSA_IDLE) begin
            if (scl_rise && bit_reg < BIT_ACK) begin
               shift_reg <= rx_byte;
               bit_reg <= bit_reg + 4'h1;
            end
            if (ack_clk) begin
               bit_reg <= 4'h0;
               // master ack continues a read; nack ends it
               if (rd_mode_reg && !drive_reg && sda) begin
                  state_reg <= MPSA_IDLE;
                  rd_mode_reg <= 1'b0;
               end else if (rd_mode_reg && !drive_reg && state_reg == MPSA_RDATA) begin
                  // ack advances pointer, byte fetched next cycle
                  ptr_reg <= ptr_inc;
                  reload_reg <= 1'b1;
               end
            end
            if (byte_done) begin
               ack_reg <= 1'b0;
               case (state_reg)
                  MPSA_ADDR: begin
                     rd_mode_reg <= 1'b0;
                     if (hit_ara) begin
                        ack_reg <= 1'b1;
                        state_reg <= MPSA_ARA;
                     end else if (hit_own || hit_mass) begin
                        ack_reg <= 1'b1;
                        state_reg <= rx_byte[0] ? MPSA_RDATA : MPSA_CMD;
                        release_reg <= i_alert_on_address;
                     end else begin
                        state_reg <= MPSA_IDLE;
                     end
                  end
                  MPSA_CMD: begin
                     ack_reg <= 1'b1;
                     ptr_reg <= rx_byte;
                     state_reg <= MPSA_WDATA;
                  end
                  MPSA_WDATA: begin
                     ack_reg <= 1'b1;
                     wr_reg <= 1'b1;
                     wdata_reg <= rx_byte;
                  end
                  default: begin
                     ack_reg <= 1'b0;
                  end
               endcase
            end
            if (wr_reg) begin
               ptr_reg <= ptr_inc;
            end
            // drive changes on falling clock edges only
            if (scl_fall) begin
               if (bit_reg == BIT_ACK) begin
                  drive_reg <= ack_reg;
                  if (ack_reg && (state_reg == MPSA_RDATA || state_reg == MPSA_ARA)) begin
                     rd_mode_reg <= 1'b1;
                     shift_reg <= (state_reg == MPSA_ARA) ? {own_addr, 1'b1} : i_reg_rdata;
                  end
               end else if (rd_mode_reg && bit_reg < BIT_ACK) begin
                  // drive zeros only; lose arbitration on mismatch
                  drive_reg <= ~tx_bit;
               end else begin
                  drive_reg <= 1'b0;
               end
            end
            if (rd_mode_reg && scl_rise && bit_reg < BIT_ACK && !drive_reg && !sda) begin
               // lost arbitration: stay quiet, alert kept
               state_reg <= MPSA_IDLE;
               rd_mode_reg <= 1'b0;
            end else if (ack_clk && state_reg == MPSA_ARA && rd_mode_reg && !drive_reg) begin
               release_reg <= 1'b1;
            end
            if (reload_reg) begin
               shift_reg <= i_reg_rdata;
            end
         end
      end
   end

   // -----------------------------------------------
   // outputs
   // -----------------------------------------------
   logic sdo_reg;
   logic alert_n_reg;
   // open-drain output, variant inverts; no clock output
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sdo_reg <= INVERT_OUT ? 1'b0 : 1'b1;
         alert_n_reg <= 1'b1;
      end else begin
         sdo_reg <= INVERT_OUT ? drive_reg : ~drive_reg;
         // released at reset, low while active
         alert_n_reg <= ~alert_active;
      end
   end
   assign o_serial_data_out = sdo_reg;
   assign o_alert_out_pin_n = alert_n_reg;
   assign o_reg_ptr = ptr_reg;
   assign o_reg_wr = wr_reg;
   assign o_reg_wdata = wdata_reg;

   // -----------------------------------------------
   // assertions
   // -----------------------------------------------
   sequence s_quiet;
      !stuck_reg;
   endsequence
   property p_stuck_release;
      @(posedge i_sys_clk) disable iff (!i_rst_b) stuck_reg |=> !drive_reg && state_reg == MPSA_IDLE;
   endproperty
   a_stuck_release: assert property (p_stuck_release) else $error("bus not released");
   property p_timer_clear;
      @(posedge i_sys_clk) disable iff (!i_rst_b) !any_low |=> stuck_cnt_reg == 24'h0;
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");
   property p_stop_ptr;
      @(posedge i_sys_clk) disable iff (!i_rst_b) stop_det && !stuck_reg && !start_det |=> ptr_reg == PTR_RESET;
   endproperty
   a_stop_ptr: assert property (p_stop_ptr) else $error("pointer not reset");
   property p_wrap;
      @(posedge i_sys_clk) disable iff (!i_rst_b) ptr_reg == PTR_LAST && wr_reg && !stop_det && !stuck_reg && !start_det |=> ptr_reg == PTR_RESET;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer wrap wrong");
   property p_ara_ignored;
      @(posedge i_sys_clk) disable iff (!i_rst_b) !alert_active |-> state_reg != MPSA_ARA || rd_mode_reg;
   endproperty
   a_ara_ignored: assert property (p_ara_ignored) else $error("alert address answered");
   property p_alert_pin;
      @(posedge i_sys_clk) disable iff (!i_rst_b) s_quiet ##0 alert_active |=> !o_alert_out_pin_n;
   endproperty
   a_alert_pin: assert property (p_alert_pin) else $error("alert pin not low");
   property p_write_strobe;
      @(posedge i_sys_clk) disable iff (!i_rst_b) wr_reg |-> $past(state_reg) == MPSA_WDATA;
   endproperty
   a_write_strobe: assert property (p_write_strobe) else $error("stray write");
   property p_ack_timing;
      @(posedge i_sys_clk) disable iff (!i_rst_b) drive_reg && $rose(drive_reg) |-> bit_reg == BIT_ACK || rd_mode_reg;
   endproperty
   a_ack_timing: assert property (p_ack_timing) else $error("drive outside slot");
endmodule
`default_nettype wire

// [pkg/mpsa_pkg.sv]
// package of constants for the two-wire slave with alert
package mpsa_pkg;
   localparam int CLK_MHZ = 250;
   localparam int STUCK_MS = 33;
   localparam int STUCK_CYC = STUCK_MS * 1000 * CLK_MHZ;
   localparam logic [2:0] ADDR_TOP = 3'h6;
   localparam logic [6:0] MASS_WR_ADDR = 7'h66;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_LAST = 8'h97;
   localparam int ALERT_BIT_CONTROL_REG_B = 7;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // three-state strap levels per address pin
   localparam logic [1:0] STRAP_L = 2'h0;
   localparam logic [1:0] STRAP_H = 2'h1;
   localparam logic [1:0] STRAP_NC = 2'h2;
   typedef enum logic [2:0] {
      MPSA_IDLE = 3'b000,
      MPSA_ADDR = 3'b001,
      MPSA_CMD = 3'b010,
      MPSA_WDATA = 3'b011,
      MPSA_RDATA = 3'b100,
      MPSA_ARA = 3'b101
   } mpsa_state_t;
endpackage

// [verilog/mpsa_alert.sv]
// alert output latch with fault edge detection and release
`timescale 1ns/1ps
`default_nettype none
module mpsa_alert (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // fault and enable words
   input wire logic [31:0] i_fault_flags,
   input wire logic [31:0] i_alert_enable,
   // release request
   input wire logic i_release,
   // alert asserted state, active high
   output logic o_alert_active
);
   import mpsa_pkg::*;
   logic [31:0] fault_prev_reg;
   logic active_reg;
   wire [31:0] new_fault = i_fault_flags & ~fault_prev_reg & i_alert_enable;
   // new enabled fault raises alert; only on new edge
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fault_prev_reg <= 32'h0;
         active_reg <= 1'b0;
      end else begin
         fault_prev_reg <= i_fault_flags;
         if (|new_fault) begin
            active_reg <= 1'b1;
         end else if (i_release) begin
            active_reg <= 1'b0;
         end
      end
   end
   assign o_alert_active = active_reg;
endmodule
`default_nettype wire

// [test/mpsa_i2c_master.sv]
// two-wire bus master model driving the bus clock and data line
`timescale 1ns/1ps
`default_nettype none
module mpsa_i2c_master (
   // clock
   input wire logic i_sys_clk,
   // resolved data line
   input wire logic i_sda,
   // bus drive, data high means released
   output logic o_scl,
   output logic o_sda_drv
);
   // --------------------------------------------------
   // bus phases
   // --------------------------------------------------
   // idle bus, both lines high
   initial begin
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
   end
   // one quarter of a bit, five clocks
   task automatic q();
      repeat (5) @(negedge i_sys_clk);
   endtask
   task automatic bus_start();
      o_sda_drv = 1'b1;
      q();
      o_scl = 1'b1;
      q();
      o_sda_drv = 1'b0;
      q();
      o_scl = 1'b0;
      q();
   endtask
   task automatic bus_stop();
      o_sda_drv = 1'b0;
      q();
      o_scl = 1'b1;
      q();
      o_sda_drv = 1'b1;
      q();
   endtask
   // release both lines at once
   task automatic bus_free();
      o_scl = 1'b1;
      o_sda_drv = 1'b1;
      q();
   endtask
   // one clock pulse, data sampled while clock high
   task automatic bit_xfer(input logic b, output logic s);
      o_sda_drv = b;
      q();
      o_scl = 1'b1;
      q();
      s = i_sda;
      q();
      o_scl = 1'b0;
      q();
   endtask
   // byte out msb first, ack bit back (low = acked)
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], s);
      end
      bit_xfer(1'b1, ack);
   endtask
   // byte in, then master ack or nack
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, s);
         d[i] = s;
      end
      bit_xfer(nack, s);
   endtask
endmodule
`default_nettype wire

// [test/test_mpsa_slave.sv]
// self-checking bench for the two-wire slave with alert
`timescale 1ns/1ps
`default_nettype none
module test_mpsa_slave;
   import mpsa_pkg::*;
   // --------------------------------------------------
   // signals and models
   // --------------------------------------------------
   localparam int STK = 200;
   typedef struct packed {
      logic [1:0] p1;
      logic [1:0] p0;
      logic [7:0] ab;
      logic ack;
   } mpsa_row_t;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] strap_1 = STRAP_NC;
   logic [1:0] strap_0 = STRAP_NC;
   logic [31:0] fault = 32'h0;
   logic [31:0] enable = 32'h0;
   logic alert_on_addr = 1'b0;
   logic [7:0] regs [256];
   int fail_count = 0;
   int tests_run = 0;
   int wr_count = 0;
   int cyc = 0;
   wire scl;
   wire m_sda;
   wire sda_out;
   wire sda_out_inv;
   wire sda;
   wire alert_n;
   wire reg_wr;
   wire [7:0] ptr;
   wire [7:0] wdata;
   wire [7:0] rdata;
   // strap, address byte, expected ack
   mpsa_row_t rows [9] = '{
      '{STRAP_H, STRAP_L, 8'hCE, 1'b0},
      '{STRAP_NC, STRAP_H, 8'hD0, 1'b0},
      '{STRAP_H, STRAP_H, 8'hD2, 1'b0},
      '{STRAP_NC, STRAP_NC, 8'hD4, 1'b0},
      '{STRAP_NC, STRAP_L, 8'hD6, 1'b0},
      '{STRAP_L, STRAP_H, 8'hD8, 1'b0},
      '{STRAP_NC, STRAP_NC, 8'hCC, 1'b0},
      '{STRAP_NC, STRAP_NC, 8'h19, 1'b1},
      '{STRAP_H, STRAP_L, 8'hD0, 1'b1}
   };
   always #2 sys_clk = ~sys_clk;
   assign sda = m_sda & sda_out;
   // register file seen by the slave
   assign rdata = regs[ptr];
   always @(posedge sys_clk) begin
      if (reg_wr === 1'b1) begin
         regs[ptr] <= wdata;
         wr_count <= wr_count + 1;
      end
   end
   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count = fail_count + 1;
         end_sim();
      end
   end
   mpsa_i2c_master u_master (
      .i_sys_clk(sys_clk),
      .i_sda(sda),
      .o_scl(scl),
      .o_sda_drv(m_sda)
   );
   mpsa_slave #(.STUCK_CYCLES(STK), .INVERT_OUT(1'b0)) u_dut (
      .i_sys_clk(sys_clk),
      .i_rst_b(rst_b),
      .i_scl(scl),
      .i_serial_data_in(sda),
      .o_serial_data_out(sda_out),
      .i_addr_select_pin_0(strap_0),
      .i_addr_select_pin_1(strap_1),
      .i_fault_flags(fault),
      .i_alert_enable(enable),
      .i_alert_on_address(alert_on_addr),
      .o_alert_out_pin_n(alert_n),
      .o_reg_ptr(ptr),
      .o_reg_wr(reg_wr),
      .o_reg_wdata(wdata),
      .i_reg_rdata(rdata)
   );
   // inverted-output variant listening on the same bus
   mpsa_slave #(.STUCK_CYCLES(STK), .INVERT_OUT(1'b1)) u_dut_inv (
      .i_sys_clk(sys_clk),
      .i_rst_b(rst_b),
      .i_scl(scl),
      .i_serial_data_in(sda),
      .o_serial_data_out(sda_out_inv),
      .i_addr_select_pin_0(strap_0),
      .i_addr_select_pin_1(strap_1),
      .i_fault_flags(fault),
      .i_alert_enable(enable),
      .i_alert_on_address(alert_on_addr),
      .o_alert_out_pin_n(),
      .o_reg_ptr(),
      .o_reg_wr(),
      .o_reg_wdata(),
      .i_reg_rdata(rdata)
   );
   // --------------------------------------------------
   // checks and sequence
   // --------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // open a write to the own address with a command byte
   task automatic open_cmd(input logic [7:0] cmd);
      logic a;
      u_master.bus_start();
      u_master.wr_byte(8'hD4, a);
      u_master.wr_byte(cmd, a);
   endtask
   initial begin
      logic a;
      logic [7:0] d;
      foreach (regs[i]) regs[i] = 8'h00;
      repeat (3) @(negedge sys_clk);
      chk_bit(sda_out, 1'b1);
      chk_bit(sda_out_inv, 1'b0);
      chk_bit(alert_n, 1'b1);
      chk_byte(ptr, PTR_RESET);
      rst_b = 1'b1;
      repeat (3) @(negedge sys_clk);
      foreach (rows[i]) begin
         strap_1 = rows[i].p1;
         strap_0 = rows[i].p0;
         u_master.bus_start();
         u_master.wr_byte(rows[i].ab, a);
         chk_bit(a, rows[i].ack);
         u_master.bus_stop();
      end
      $display("address table done");
      strap_1 = STRAP_NC;
      strap_0 = STRAP_NC;
      open_cmd(8'h96);
      chk_byte(ptr, 8'h96);
      u_master.wr_byte(8'hA1, a);
      u_master.wr_byte(8'hB2, a);
      u_master.wr_byte(8'hC3, a);
      chk_bit(a, 1'b0);
      chk_byte(ptr, 8'h01);
      u_master.bus_stop();
      repeat (10) @(negedge sys_clk);
      chk_byte(ptr, PTR_RESET);
      chk_byte(regs[8'h96], 8'hA1);
      chk_byte(regs[8'h97], 8'hB2);
      chk_byte(regs[8'h00], 8'hC3);
      chk_byte(8'(wr_count), 8'h03);
      $display("page write done");
      open_cmd(8'h97);
      u_master.bus_start();
      u_master.wr_byte(8'hD5, a);
      chk_bit(a, 1'b0);
      u_master.rd_byte(1'b0, d);
      chk_byte(d, 8'hB2);
      u_master.rd_byte(1'b1, d);
      chk_byte(d, 8'hC3);
      u_master.bus_stop();
      repeat (10) @(negedge sys_clk);
      chk_byte(ptr, PTR_RESET);
      $display("page read done");
      enable = 32'h0000_0003;
      fault = 32'h0000_0001;
      repeat (10) @(negedge sys_clk);
      chk_bit(alert_n, 1'b0);
      u_master.bus_start();
      u_master.wr_byte(8'h19, a);
      chk_bit(a, 1'b0);
      u_master.rd_byte(1'b1, d);
      chk_byte(d, 8'hD5);
      u_master.bus_stop();
      repeat (10) @(negedge sys_clk);
      chk_bit(alert_n, 1'b1);
      fault = 32'h0000_0003;
      repeat (10) @(negedge sys_clk);
      chk_bit(alert_n, 1'b0);
      u_master.bus_start();
      u_master.wr_byte(8'h19, a);
      u_master.wr_byte(8'h7F, a);
      chk_bit(a, 1'b1);
      u_master.bus_stop();
      repeat (10) @(negedge sys_clk);
      chk_bit(alert_n, 1'b0);
      alert_on_addr = 1'b1;
      open_cmd(8'h10);
      u_master.bus_stop();
      repeat (10) @(negedge sys_clk);
      chk_bit(alert_n, 1'b1);
      $display("alert done");
      d = 8'hD4;
      u_master.bus_start();
      for (int i = 7; i >= 0; i--) begin
         u_master.bit_xfer(d[i], a);
      end
      repeat (6) @(negedge sys_clk);
      chk_bit(sda_out, 1'b0);
      chk_bit(sda_out_inv, 1'b1);
      repeat (STK + 20) @(negedge sys_clk);
      chk_bit(sda_out, 1'b1);
      chk_bit(sda_out_inv, 1'b0);
      u_master.bus_free();
      u_master.wr_byte(8'hD4, a);
      chk_bit(a, 1'b1);
      u_master.bus_stop();
      u_master.bus_start();
      u_master.wr_byte(8'hD4, a);
      chk_bit(a, 1'b0);
      u_master.bus_stop();
      $display("stuck bus done");
      end_sim();
   end
endmodule
`default_nettype wire
